// *** rtl/iop_pkg.sv ***
package iop_pkg;
   // ==================================================
   // register byte offsets
   localparam logic [7:0] IOP_OFS_A_VALUE = 8'h00;
   localparam logic [7:0] IOP_OFS_B_VALUE = 8'h04;
   localparam logic [7:0] IOP_OFS_A_DIR = 8'h08;
   localparam logic [7:0] IOP_OFS_B_DIR = 8'h0C;
   localparam logic [7:0] IOP_OFS_A_PULLUP = 8'h10;
   localparam logic [7:0] IOP_OFS_PULLDOWN = 8'h14;
   localparam logic [7:0] IOP_OFS_B_PULLUP = 8'h18;
   localparam logic [7:0] IOP_OFS_B_OD = 8'h1C;
   localparam logic [7:0] IOP_OFS_A_WAKE = 8'h20;
   localparam logic [7:0] IOP_OFS_B_WAKE = 8'h24;
   localparam logic [7:0] IOP_OFS_PWR = 8'h28;
   localparam logic [7:0] IOP_OFS_PWR_ONE = 8'h2C;
   localparam logic [7:0] IOP_OFS_IRQ_FLAG = 8'h30;
   localparam logic [7:0] IOP_OFS_IRQ_EN = 8'h34;
   localparam logic [7:0] IOP_OFS_EXT_EDGE = 8'h38;
   localparam logic [7:0] IOP_OFS_READ_SEL = 8'h3C;
   localparam logic [7:0] IOP_OFS_ALT_SEL = 8'h40;

   // ==================================================
   // field positions
   localparam int IOP_PIN_CHG_BIT = 1;
   localparam int IOP_GIE_BIT = 7;
   localparam int IOP_PA5_PU_BIT = 4;
   localparam int IOP_EXT_IRQ0_PIN_SELECT_BIT = 4;
   localparam int IOP_EXT_IRQ1_PIN_SELECT_BIT = 5;
   localparam int IOP_RSEL_B_LSB = 8;
   localparam int IOP_ALT_CMP_OE = 0;
   localparam int IOP_ALT_PWM1_OE = 1;
   localparam int IOP_ALT_BZ1_EN = 2;
   localparam int IOP_ALT_PWM2_OE = 3;
   localparam int IOP_ALT_BZ2_EN = 4;
   localparam int IOP_ALT_IR_EN = 5;
   localparam int IOP_ALT_TIMER0_SOURCE_SELECT = 6;
   localparam int IOP_ALT_T0SLOW = 7;
   localparam int IOP_ALT_TIMER1_SOURCE_SELECT = 8;
   localparam int IOP_ALT_TIMER2_SOURCE_SELECT = 9;
   localparam int IOP_ALT_TIMER3_SOURCE_SELECT = 10;

   // ==================================================
   // reset values
   localparam logic [7:0] IOP_RST_A_DIR = 8'hFF;
   localparam logic [5:0] IOP_RST_B_DIR = 6'h3F;
   localparam logic [7:0] IOP_RST_BYTE = 8'h00;
   localparam logic [5:0] IOP_RST_SIX = 6'h00;
   localparam logic [10:0] IOP_RST_ALT = 11'h000;

   // ==================================================
   // bus phase
   typedef enum logic [1:0] {
      IOP_ST_IDLE = 2'b00,
      IOP_ST_ACK = 2'b01
   } iop_state_t;
endpackage

// *** rtl/iop_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - fourteen pins, two ports, data registers
// - per-pin direction bits for both ports
// - pulls act only on input pins
// - port A pull-high bits 7,6,4:0
// - pull-low map: A5, A3:0, B3:0
// - port B pull-high bits 5:0
// - A5 pull-high from power register bit4
// - port B per-pin open-drain select
// - per-pin level-change select, both ports
// - level change sets pin-change flag bit1
// - request needs flag, enable, global enable
// - edge bits 4,5 route B0,B1 interrupts
// - external interrupt masks B0/B1 change
// - IR carrier on B1 when enabled
// - A5 optional active-low reset input
// - crystal takes A6 in, A7 out
// - internal osc clock-out on A7
// - A4 feeds timer0/timer1 count clock
// - A1 feeds timer2/timer3 count clock
// - B3: comparator, then pwm1, then buzzer1
// - B2: pwm2 over buzzer2
// - read selects pad or output latch
module iop_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // port a pads
   input wire logic [7:0] pa_in,
   output logic [7:0] pa_out,
   output logic [7:0] pa_oe,
   output logic [7:0] pa_pullup_en,
   output logic [7:0] pa_pulldown_en,
   // port b pads
   input wire logic [5:0] pb_in,
   output logic [5:0] pb_out,
   output logic [5:0] pb_oe,
   output logic [5:0] pb_pullup_en,
   output logic [5:0] pb_pulldown_en,
   // configuration words
   input wire logic cfg_reset_pin,
   input wire logic cfg_ext_crystal,
   input wire logic cfg_internal_osc,
   input wire logic cfg_clock_out,
   // alternate function sources
   input wire logic instr_clk,
   input wire logic comparator_out,
   input wire logic timer1_pulse_out,
   input wire logic buzzer1_out,
   input wire logic timer2_pulse_out,
   input wire logic buzzer2_out,
   input wire logic ir_carrier,
   // alternate function sinks
   output logic timer0_count_clk,
   output logic timer1_count_clk,
   output logic timer2_count_clk,
   output logic timer3_count_clk,
   output logic ext_irq0,
   output logic ext_irq1,
   output logic ext_reset_n,
   output logic crystal_en,
   output logic pin_change_irq
);

   // ==================================================
   // state
   typedef struct packed {
      iop_pkg::iop_state_t st;
      logic [31:0] rdata;
      logic err;
      logic [7:0] a_lat;
      logic [5:0] b_lat;
      logic [7:0] a_dir;
      logic [5:0] b_dir;
      logic [7:0] a_pu;
      logic [7:0] pd;
      logic [5:0] b_pu;
      logic [5:0] b_od;
      logic [7:0] a_wk;
      logic [5:0] b_wk;
      logic [7:0] pwr;
      logic [7:0] pwr1;
      logic flag;
      logic ien;
      logic [7:0] edg;
      logic [7:0] rsel_a;
      logic [5:0] rsel_b;
      logic [10:0] alt;
      logic [7:0] prev_a;
      logic [5:0] prev_b;
      logic prev_ok;
   } iop_regs_t;

   iop_regs_t s_q;
   iop_regs_t s_d;

   logic [7:0] a_rd;
   logic [5:0] b_rd;
   logic [7:0] chg_a;
   logic [5:0] chg_b;
   logic [5:0] ext_mask;
   logic chg_any;
   logic wr_go;
   logic [7:0] wb;
   logic [7:0] a_ovr;
   logic xtal;
   logic clkout;
   logic pb3_alt;
   logic pb2_alt;
   logic pb1_alt;
   logic pb3_val;
   logic pb2_val;

   // ==================================================
   // address decode
   function automatic logic hit(input logic [11:0] a);
      logic ok;
      ok = 1'b0;
      if (a[11:8] == 4'h0) begin
         case (a[7:0])
            iop_pkg::IOP_OFS_A_VALUE, iop_pkg::IOP_OFS_B_VALUE,
            iop_pkg::IOP_OFS_A_DIR, iop_pkg::IOP_OFS_B_DIR,
            iop_pkg::IOP_OFS_A_PULLUP, iop_pkg::IOP_OFS_PULLDOWN,
            iop_pkg::IOP_OFS_B_PULLUP, iop_pkg::IOP_OFS_B_OD,
            iop_pkg::IOP_OFS_A_WAKE, iop_pkg::IOP_OFS_B_WAKE,
            iop_pkg::IOP_OFS_PWR, iop_pkg::IOP_OFS_PWR_ONE,
            iop_pkg::IOP_OFS_IRQ_FLAG, iop_pkg::IOP_OFS_IRQ_EN,
            iop_pkg::IOP_OFS_EXT_EDGE, iop_pkg::IOP_OFS_READ_SEL,
            iop_pkg::IOP_OFS_ALT_SEL: ok = 1'b1;
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   // ==================================================
   // read path and level change
   always_comb begin
      a_rd = (s_q.rsel_a & s_q.a_lat) | (~s_q.rsel_a & pa_in);
      b_rd = (s_q.rsel_b & s_q.b_lat) | (~s_q.rsel_b & pb_in);
      ext_mask = {4'h0, s_q.edg[iop_pkg::IOP_EXT_IRQ1_PIN_SELECT_BIT],
                  s_q.edg[iop_pkg::IOP_EXT_IRQ0_PIN_SELECT_BIT]};
      chg_a = (pa_in ^ s_q.prev_a) & s_q.a_wk & {8{s_q.prev_ok}};
      chg_b = (pb_in ^ s_q.prev_b) & s_q.b_wk & ~ext_mask
              & {6{s_q.prev_ok}};
      chg_any = (|chg_a) | (|chg_b);
   end

   // ==================================================
   // next state
   always_comb begin
      s_d = s_q;
      wr_go = 1'b0;
      wb = pwdata[7:0];
      s_d.prev_a = pa_in;
      s_d.prev_b = pb_in;
      s_d.prev_ok = 1'b1;
      case (s_q.st)
         iop_pkg::IOP_ST_IDLE: begin
            if (psel && !penable) begin
               s_d.st = iop_pkg::IOP_ST_ACK;
               s_d.err = ~hit(paddr);
               s_d.rdata = 32'h0000_0000;
               case (paddr[7:0])
                  iop_pkg::IOP_OFS_A_VALUE: s_d.rdata[7:0] = a_rd;
                  iop_pkg::IOP_OFS_B_VALUE: s_d.rdata[5:0] = b_rd;
                  iop_pkg::IOP_OFS_A_DIR: s_d.rdata[7:0] = s_q.a_dir;
                  iop_pkg::IOP_OFS_B_DIR: s_d.rdata[5:0] = s_q.b_dir;
                  iop_pkg::IOP_OFS_A_PULLUP: s_d.rdata[7:0] = s_q.a_pu;
                  iop_pkg::IOP_OFS_PULLDOWN: s_d.rdata[7:0] = s_q.pd;
                  iop_pkg::IOP_OFS_B_PULLUP: s_d.rdata[5:0] = s_q.b_pu;
                  iop_pkg::IOP_OFS_B_OD: s_d.rdata[5:0] = s_q.b_od;
                  iop_pkg::IOP_OFS_A_WAKE: s_d.rdata[7:0] = s_q.a_wk;
                  iop_pkg::IOP_OFS_B_WAKE: s_d.rdata[5:0] = s_q.b_wk;
                  iop_pkg::IOP_OFS_PWR: s_d.rdata[7:0] = s_q.pwr;
                  iop_pkg::IOP_OFS_PWR_ONE: s_d.rdata[7:0] = s_q.pwr1;
                  iop_pkg::IOP_OFS_IRQ_FLAG:
                     s_d.rdata[iop_pkg::IOP_PIN_CHG_BIT] = s_q.flag;
                  iop_pkg::IOP_OFS_IRQ_EN:
                     s_d.rdata[iop_pkg::IOP_PIN_CHG_BIT] = s_q.ien;
                  iop_pkg::IOP_OFS_EXT_EDGE: s_d.rdata[7:0] = s_q.edg;
                  iop_pkg::IOP_OFS_READ_SEL:
                     s_d.rdata[13:0] = {s_q.rsel_b, s_q.rsel_a};
                  iop_pkg::IOP_OFS_ALT_SEL: s_d.rdata[10:0] = s_q.alt;
                  default: s_d.rdata = 32'h0000_0000;
               endcase
               if (paddr[11:8] != 4'h0) begin
                  s_d.rdata = 32'h0000_0000;
               end
            end
         end
         iop_pkg::IOP_ST_ACK: begin
            if (psel && penable) begin
               s_d.st = iop_pkg::IOP_ST_IDLE;
               wr_go = pwrite & ~s_q.err;
            end else begin
               s_d.st = iop_pkg::IOP_ST_IDLE;
            end
         end
         default: s_d.st = iop_pkg::IOP_ST_IDLE;
      endcase
      if (wr_go) begin
         case (paddr[7:0])
            iop_pkg::IOP_OFS_A_VALUE: s_d.a_lat = wb;
            iop_pkg::IOP_OFS_B_VALUE: s_d.b_lat = wb[5:0];
            iop_pkg::IOP_OFS_A_DIR: s_d.a_dir = wb;
            iop_pkg::IOP_OFS_B_DIR: s_d.b_dir = wb[5:0];
            iop_pkg::IOP_OFS_A_PULLUP: s_d.a_pu = wb;
            iop_pkg::IOP_OFS_PULLDOWN: s_d.pd = wb;
            iop_pkg::IOP_OFS_B_PULLUP: s_d.b_pu = wb[5:0];
            iop_pkg::IOP_OFS_B_OD: s_d.b_od = wb[5:0];
            iop_pkg::IOP_OFS_A_WAKE: s_d.a_wk = wb;
            iop_pkg::IOP_OFS_B_WAKE: s_d.b_wk = wb[5:0];
            iop_pkg::IOP_OFS_PWR: s_d.pwr = wb;
            iop_pkg::IOP_OFS_PWR_ONE: s_d.pwr1 = wb;
            iop_pkg::IOP_OFS_IRQ_FLAG:
               s_d.flag = s_q.flag & wb[iop_pkg::IOP_PIN_CHG_BIT];
            iop_pkg::IOP_OFS_IRQ_EN:
               s_d.ien = wb[iop_pkg::IOP_PIN_CHG_BIT];
            iop_pkg::IOP_OFS_EXT_EDGE: s_d.edg = wb;
            iop_pkg::IOP_OFS_READ_SEL: begin
               s_d.rsel_a = pwdata[7:0];
               s_d.rsel_b = pwdata[iop_pkg::IOP_RSEL_B_LSB +: 6];
            end
            iop_pkg::IOP_OFS_ALT_SEL: s_d.alt = pwdata[10:0];
            default: s_d.alt = s_q.alt;
         endcase
      end
      if (chg_any) begin
         s_d.flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_q.st <= iop_pkg::IOP_ST_IDLE;
         s_q.rdata <= 32'h0000_0000;
         s_q.err <= 1'b0;
         s_q.a_lat <= iop_pkg::IOP_RST_BYTE;
         s_q.b_lat <= iop_pkg::IOP_RST_SIX;
         s_q.a_dir <= iop_pkg::IOP_RST_A_DIR;
         s_q.b_dir <= iop_pkg::IOP_RST_B_DIR;
         s_q.a_pu <= iop_pkg::IOP_RST_BYTE;
         s_q.pd <= iop_pkg::IOP_RST_BYTE;
         s_q.b_pu <= iop_pkg::IOP_RST_SIX;
         s_q.b_od <= iop_pkg::IOP_RST_SIX;
         s_q.a_wk <= iop_pkg::IOP_RST_BYTE;
         s_q.b_wk <= iop_pkg::IOP_RST_SIX;
         s_q.pwr <= iop_pkg::IOP_RST_BYTE;
         s_q.pwr1 <= iop_pkg::IOP_RST_BYTE;
         s_q.flag <= 1'b0;
         s_q.ien <= 1'b0;
         s_q.edg <= iop_pkg::IOP_RST_BYTE;
         s_q.rsel_a <= iop_pkg::IOP_RST_BYTE;
         s_q.rsel_b <= iop_pkg::IOP_RST_SIX;
         s_q.alt <= iop_pkg::IOP_RST_ALT;
         s_q.prev_a <= iop_pkg::IOP_RST_BYTE;
         s_q.prev_b <= iop_pkg::IOP_RST_SIX;
         s_q.prev_ok <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==================================================
   // apb answer
   always_comb begin
      pready = psel & penable & (s_q.st == iop_pkg::IOP_ST_ACK);
      pslverr = pready & s_q.err;
      prdata = s_q.rdata;
   end

   // ==================================================
   // pads and alternate functions
   always_comb begin
      xtal = cfg_ext_crystal;
      clkout = cfg_internal_osc & ~cfg_ext_crystal & cfg_clock_out;
      a_ovr = {xtal | clkout, xtal, cfg_reset_pin, 5'h00};
      pb3_alt = s_q.alt[iop_pkg::IOP_ALT_CMP_OE]
                | s_q.alt[iop_pkg::IOP_ALT_PWM1_OE]
                | s_q.alt[iop_pkg::IOP_ALT_BZ1_EN];
      if (s_q.alt[iop_pkg::IOP_ALT_CMP_OE]) begin
         pb3_val = comparator_out;
      end else if (s_q.alt[iop_pkg::IOP_ALT_PWM1_OE]) begin
         pb3_val = timer1_pulse_out;
      end else begin
         pb3_val = buzzer1_out;
      end
      pb2_alt = s_q.alt[iop_pkg::IOP_ALT_PWM2_OE]
                | s_q.alt[iop_pkg::IOP_ALT_BZ2_EN];
      if (s_q.alt[iop_pkg::IOP_ALT_PWM2_OE]) begin
         pb2_val = timer2_pulse_out;
      end else begin
         pb2_val = buzzer2_out;
      end
      pb1_alt = s_q.alt[iop_pkg::IOP_ALT_IR_EN];

      pa_oe = ~s_q.a_dir & ~a_ovr;
      pa_out = s_q.a_lat;
      // pa5 drives low only
      pa_oe[5] = ~s_q.a_dir[5] & ~s_q.a_lat[5] & ~cfg_reset_pin;
      pa_out[5] = 1'b0;
      if (clkout) begin
         pa_oe[7] = 1'b1;
         pa_out[7] = instr_clk;
      end
      pa_pullup_en = {s_q.a_pu[7:6], s_q.pwr[iop_pkg::IOP_PA5_PU_BIT],
                      s_q.a_pu[4:0]} & s_q.a_dir
                     & ~{xtal | clkout, xtal, 6'h00};
      pa_pulldown_en = {2'b00, s_q.a_pu[5], 1'b0, s_q.pd[3:0]}
                       & s_q.a_dir;

      pb_oe = ~s_q.b_dir & (~s_q.b_od | ~s_q.b_lat);
      pb_out = s_q.b_lat & ~s_q.b_od;
      if (pb1_alt) begin
         pb_oe[1] = 1'b1;
         pb_out[1] = ir_carrier;
      end
      if (pb2_alt) begin
         pb_oe[2] = 1'b1;
         pb_out[2] = pb2_val;
      end
      if (pb3_alt) begin
         pb_oe[3] = 1'b1;
         pb_out[3] = pb3_val;
      end
      pb_pullup_en = s_q.b_pu & s_q.b_dir & ~pb_oe;
      pb_pulldown_en = {2'b00, s_q.pd[7:4]} & s_q.b_dir & ~pb_oe;

      timer0_count_clk = pa_in[4] & s_q.alt[iop_pkg::IOP_ALT_TIMER0_SOURCE_SELECT]
                         & ~s_q.alt[iop_pkg::IOP_ALT_T0SLOW];
      timer1_count_clk = pa_in[4] & s_q.alt[iop_pkg::IOP_ALT_TIMER1_SOURCE_SELECT];
      timer2_count_clk = pa_in[1] & s_q.alt[iop_pkg::IOP_ALT_TIMER2_SOURCE_SELECT];
      timer3_count_clk = pa_in[1] & s_q.alt[iop_pkg::IOP_ALT_TIMER3_SOURCE_SELECT];
      ext_irq0 = pb_in[0] & s_q.edg[iop_pkg::IOP_EXT_IRQ0_PIN_SELECT_BIT];
      ext_irq1 = pb_in[1] & s_q.edg[iop_pkg::IOP_EXT_IRQ1_PIN_SELECT_BIT];
      ext_reset_n = ~cfg_reset_pin | pa_in[5];
      crystal_en = xtal;
      pin_change_irq = s_q.flag & s_q.ien & s_q.pwr1[iop_pkg::IOP_GIE_BIT];
   end

endmodule

// *** verif/iop_port_checker.sv ***
`timescale 1ns/1ps
// ========================
// port behaviour checker
module iop_port_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // pads
   input wire logic [7:0] pa_in,
   input wire logic [7:0] pa_out,
   input wire logic [7:0] pa_oe,
   input wire logic [7:0] pa_pullup_en,
   input wire logic [7:0] pa_pulldown_en,
   input wire logic [5:0] pb_in,
   input wire logic [5:0] pb_oe,
   input wire logic [5:0] pb_pullup_en,
   input wire logic [5:0] pb_pulldown_en,
   // configuration and alternates
   input wire logic cfg_reset_pin,
   input wire logic cfg_ext_crystal,
   input wire logic cfg_internal_osc,
   input wire logic cfg_clock_out,
   input wire logic instr_clk,
   input wire logic timer0_count_clk,
   input wire logic ext_irq0,
   input wire logic ext_reset_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   bus_answer_a: assert property (setup_s ##1 access_s |-> pready)
      else $error("no ready in first access cycle");
   ready_pulse_a: assert property (pready |-> access_s ##1 !pready)
      else $error("ready outside one access cycle");
   pa_pull_a: assert property (
      ((pa_pullup_en | pa_pulldown_en) & pa_oe) == 8'h00)
      else $error("pull on a driven port a pin");
   pb_pull_a: assert property (
      ((pb_pullup_en | pb_pulldown_en) & pb_oe) == 6'h00)
      else $error("pull on a driven port b pin");
   pulldown_map_a: assert property (
      {pa_pulldown_en[7:6], pa_pulldown_en[4], pb_pulldown_en[5:4]}
      == 5'h00)
      else $error("pull-low on a pin without one");
   ext_irq_a: assert property (ext_irq0 |-> pb_in[0])
      else $error("interrupt input not following pin");
   reset_pin_a: assert property (
      ext_reset_n == (cfg_reset_pin ? pa_in[5] : 1'b1))
      else $error("reset input wrong");
   crystal_a: assert property (
      cfg_ext_crystal |-> {pa_oe[7:6], pa_pullup_en[7:6]} == 4'h0)
      else $error("crystal pins still in use");
   clock_out_a: assert property (
      cfg_internal_osc && !cfg_ext_crystal && cfg_clock_out
      |-> pa_oe[7] && pa_out[7] == instr_clk)
      else $error("clock out missing");
   count_clk_a: assert property (timer0_count_clk |-> pa_in[4])
      else $error("count clock without pin level");
endmodule
bind iop_port iop_port_checker i_iop_port_checker (.*);

// *** verif/iop_pad_model.sv ***
`timescale 1ns/1ps
// ========================
// pad wire resolver
module iop_pad_model #(
   parameter int W = 8
) (
   // clock
   input wire logic clk,
   // design side
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] pu,
   input wire logic [W-1:0] pd,
   // outside driver
   input wire logic [W-1:0] ext,
   input wire logic [W-1:0] ext_en,
   // level seen
   output logic [W-1:0] pad
);
   // undriven, unpulled pins wander
   logic [W-1:0] flt_q = '0;
   always_ff @(posedge clk) begin
      flt_q <= ~pad;
   end
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pad[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 :
            pd[i] ? 1'b0 : flt_q[i];
      end
   end
endmodule

// *** verif/iop_port_bench.sv ***
`timescale 1ns/1ps
// ========================
// bench top
module iop_port_bench;
   logic core_clk = 1'b0, rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic pready, pslverr, rerr;
   logic [7:0] pa_in, pa_out, pa_oe, pa_pullup_en, pa_pulldown_en;
   logic [5:0] pb_in, pb_out, pb_oe, pb_pullup_en, pb_pulldown_en;
   logic [7:0] ea = 8'h00, ea_en = 8'hff;
   logic [5:0] eb = 6'h00;
   logic cfg_reset_pin = 1'b0, cfg_ext_crystal = 1'b0;
   logic cfg_internal_osc = 1'b0, cfg_clock_out = 1'b0;
   logic instr_clk = 1'b0, comparator_out = 1'b0, ir_carrier = 1'b0;
   logic timer1_pulse_out = 1'b0, buzzer1_out = 1'b0;
   logic timer2_pulse_out = 1'b0, buzzer2_out = 1'b0;
   logic timer0_count_clk, timer1_count_clk, timer2_count_clk;
   logic timer3_count_clk, ext_irq0, ext_irq1, ext_reset_n;
   logic crystal_en, pin_change_irq;
   logic [10:0] alt_v [12] = '{11'h020, 11'h000, 11'h007, 11'h006,
      11'h004, 11'h018, 11'h010, 11'h040, 11'h0c0, 11'h100, 11'h200,
      11'h400};
   logic [9:0] alt_e [12] = '{10'h009, 10'h000, 10'h024, 10'h020,
      10'h024, 10'h010, 10'h012, 10'h040, 10'h000, 10'h080, 10'h100,
      10'h200};
   int miscompares = 0, n_checks = 0;

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) instr_clk <= ~instr_clk;

   iop_port i_iop_port (.*);
   iop_pad_model #(.W(8)) i_iop_pad_model (.clk(core_clk), .out(pa_out),
      .oe(pa_oe), .pu(pa_pullup_en), .pd(pa_pulldown_en), .ext(ea),
      .ext_en(ea_en), .pad(pa_in));
   iop_pad_model #(.W(6)) i_iop_pad_model_b (.clk(core_clk), .out(pb_out),
      .oe(pb_oe), .pu(pb_pullup_en), .pd(pb_pulldown_en), .ext(eb),
      .ext_en(6'h3f), .pad(pb_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one apb transfer, then settle to mid cycle
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {4'h0, a};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         miscompares++;
         conclude();
      end
      @(negedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask

   task automatic pads(input logic [7:0] a, input logic [5:0] b);
      @(posedge core_clk);
      ea <= a;
      eb <= b;
      repeat (3) @(negedge core_clk);
   endtask

   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         rd(8'(i * 4), i == 2 ? 32'h0000_00ff : i == 3 ? 32'h0000_003f :
            32'h0000_0000);
      end
      rd(8'h44, 32'h0000_0000);
      chk(rerr, 1'b1);
      for (int i = 2; i < 10; i++) begin
         wr(8'(i * 4), 32'hffff_ffff);
         rd(8'(i * 4), (i inside {3, 6, 7, 9}) ? 32'h0000_003f :
            32'h0000_00ff);
         if (i > 3) wr(8'(i * 4), 32'h0000_0000);
      end
      wr(iop_pkg::IOP_OFS_A_DIR, 32'h0000_0000);
      wr(iop_pkg::IOP_OFS_A_VALUE, 32'h0000_00a5);
      chk({pa_oe, pa_out & 8'hdf}, 16'hdf85);
      wr(iop_pkg::IOP_OFS_A_VALUE, 32'h0000_005a);
      chk({pa_oe, pa_out}, 16'hff5a);
      rd(iop_pkg::IOP_OFS_A_VALUE, 32'h0000_005a);
      wr(iop_pkg::IOP_OFS_A_DIR, 32'h0000_00ff);
      wr(iop_pkg::IOP_OFS_A_PULLUP, 32'h0000_00ff);
      chk({pa_pullup_en, pa_pulldown_en}, 16'hdf20);
      wr(iop_pkg::IOP_OFS_PULLDOWN, 32'h0000_00ff);
      chk({pa_pulldown_en, 2'b00, pb_pulldown_en}, 16'h2f0f);
      wr(iop_pkg::IOP_OFS_PWR, 32'h0000_0010);
      wr(iop_pkg::IOP_OFS_B_PULLUP, 32'h0000_003f);
      chk({pa_pullup_en, 2'b00, pb_pullup_en}, 16'hff3f);
      @(posedge core_clk);
      ea_en <= 8'h00;
      repeat (3) @(negedge core_clk);
      rd(iop_pkg::IOP_OFS_A_VALUE, 32'h0000_00ff);
      wr(iop_pkg::IOP_OFS_B_DIR, 32'h0000_0000);
      chk({pb_pullup_en, pb_pulldown_en}, 12'h000);
      wr(iop_pkg::IOP_OFS_B_OD, 32'h0000_003f);
      wr(iop_pkg::IOP_OFS_B_VALUE, 32'h0000_000f);
      chk({pb_oe, pb_out & pb_oe}, 12'hc00);
      wr(iop_pkg::IOP_OFS_B_OD, 32'h0000_0000);
      chk({pb_oe, pb_out}, 12'hfcf);
      @(posedge core_clk);
      ea_en <= 8'hff;
      pads(8'hc3, 6'h00);
      wr(iop_pkg::IOP_OFS_A_VALUE, 32'h0000_003c);
      rd(iop_pkg::IOP_OFS_A_VALUE, 32'h0000_00c3);
      wr(iop_pkg::IOP_OFS_READ_SEL, 32'h0000_00ff);
      rd(iop_pkg::IOP_OFS_A_VALUE, 32'h0000_003c);
      wr(iop_pkg::IOP_OFS_READ_SEL, 32'h0000_0000);
      wr(iop_pkg::IOP_OFS_A_WAKE, 32'h0000_0001);
      pads(8'hc1, 6'h00);
      rd(iop_pkg::IOP_OFS_IRQ_FLAG, 32'h0000_0000);
      pads(8'hc0, 6'h00);
      rd(iop_pkg::IOP_OFS_IRQ_FLAG, 32'h0000_0002);
      wr(iop_pkg::IOP_OFS_IRQ_EN, 32'h0000_0002);
      chk(pin_change_irq, 1'b0);
      wr(iop_pkg::IOP_OFS_PWR_ONE, 32'h0000_0080);
      chk(pin_change_irq, 1'b1);
      rd(iop_pkg::IOP_OFS_IRQ_FLAG, 32'h0000_0002);
      wr(iop_pkg::IOP_OFS_IRQ_FLAG, 32'h0000_0000);
      rd(iop_pkg::IOP_OFS_IRQ_FLAG, 32'h0000_0000);
      chk(pin_change_irq, 1'b0);
      wr(iop_pkg::IOP_OFS_B_DIR, 32'h0000_003f);
      wr(iop_pkg::IOP_OFS_B_WAKE, 32'h0000_0003);
      wr(iop_pkg::IOP_OFS_EXT_EDGE, 32'h0000_0010);
      pads(8'hc0, 6'h01);
      rd(iop_pkg::IOP_OFS_IRQ_FLAG, 32'h0000_0000);
      chk({ext_irq1, ext_irq0}, 2'b01);
      pads(8'hc0, 6'h03);
      rd(iop_pkg::IOP_OFS_IRQ_FLAG, 32'h0000_0002);
      chk({ext_irq1, ext_irq0}, 2'b01);
      wr(iop_pkg::IOP_OFS_EXT_EDGE, 32'h0000_0030);
      chk({ext_irq1, ext_irq0}, 2'b11);
      wr(iop_pkg::IOP_OFS_A_PULLUP, 32'h0000_0000);
      wr(iop_pkg::IOP_OFS_PULLDOWN, 32'h0000_0000);
      wr(iop_pkg::IOP_OFS_B_PULLUP, 32'h0000_0000);
      @(posedge core_clk);
      comparator_out <= 1'b1;
      buzzer1_out <= 1'b1;
      buzzer2_out <= 1'b1;
      ir_carrier <= 1'b1;
      pads(8'h12, 6'h00);
      for (int i = 0; i < 12; i++) begin
         wr(iop_pkg::IOP_OFS_ALT_SEL, 32'(alt_v[i]));
         chk({timer3_count_clk, timer2_count_clk, timer1_count_clk,
            timer0_count_clk, pb_oe[3:1], pb_out[3:1] & pb_oe[3:1]},
            alt_e[i]);
      end
      @(posedge core_clk);
      cfg_reset_pin <= 1'b1;
      cfg_internal_osc <= 1'b1;
      cfg_clock_out <= 1'b1;
      @(negedge core_clk);
      chk({ext_reset_n, pa_oe[7]}, 2'b01);
      pads(8'h32, 6'h00);
      chk(ext_reset_n, 1'b1);
      wr(iop_pkg::IOP_OFS_A_DIR, 32'h0000_0000);
      chk(pa_oe[7:6], 2'b11);
      @(posedge core_clk);
      cfg_ext_crystal <= 1'b1;
      @(negedge core_clk);
      chk({pa_oe[7:6], crystal_en}, 3'b001);
      conclude();
   end
endmodule
